// ### logic/clhi_consts.svh
// constants for the character lcd host interface
`ifndef CLHI_CONSTS_SVH
`define CLHI_CONSTS_SVH
`define CLHI_CLK_PERIOD_NS 50
`define CLHI_OP_TIME_NS 2000
`define CLHI_OP_CYCLES ((`CLHI_OP_TIME_NS + `CLHI_CLK_PERIOD_NS - 1) / `CLHI_CLK_PERIOD_NS)
`define CLHI_DD_LINE1_LAST 7'h27
`define CLHI_DD_LINE2_FIRST 7'h40
`define CLHI_DD_LINE2_LAST 7'h67
`define CLHI_DD_ONE_LAST 7'h4f
`define CLHI_DD_WORDS 80
`define CLHI_CG_WORDS 64
`define CLHI_SEG_BITS 40
`define CLHI_EXT_BITS 40
`define CLHI_BIT_DL 4
`define CLHI_BIT_N 3
`define CLHI_BIT_F 2
`define CLHI_BIT_ID 1
`define CLHI_BIT_DUTY11 2
`define CLHI_FRAME_DIV 16'h0400
`endif

// ### logic/clhi_pkg.sv
// types for the character lcd host interface
package clhi_pkg;
    typedef enum logic [1:0] {
        CLHI_IDLE = 2'b00,
        CLHI_BUSY = 2'b01,
        CLHI_FILL = 2'b11
    } clhi_state_type;
    typedef enum logic [1:0] {
        CLHI_DUTY8 = 2'b00,
        CLHI_DUTY11 = 2'b01,
        CLHI_DUTY16 = 2'b10
    } clhi_duty_type;
endpackage

// ### logic/clhi_fifo.sv
// small fifo for bytes written by the host
`timescale 1ns/100ps
module clhi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } clhi_fifo_type;
    clhi_fifo_type st_r, st_nxt;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic full, empty;
    assign empty = st_r.wp == st_r.rp;
    assign full = (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]) && (st_r.wp[AW] != st_r.rp[AW]);
    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem_r[st_r.rp[AW-1:0]];
    always_comb begin
        st_nxt = st_r;
        if (i_in_valid && !full) begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (i_out_ready && !empty) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
    end
    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
        if (i_in_valid && !full) begin
            mem_r[st_r.wp[AW-1:0]] <= i_in_data;
        end
    end
endmodule

// ### logic/clhi_top.sv
// host port, ram transfer and extension driver logic of the lcd controller
`timescale 1ns/100ps
`include "clhi_consts.svh"
// Function
// - path select high data, low instruction
// - read when high, write when low
// - transfer only on enable strobe
// - low lines carry low bits 8-bit
// - high lines carry both nibbles 4-bit
// - busy shown on top bus line
// - bus width from instruction register bit
// - after data read, prefetch next ram
// - after data write, copy into ram
// - instruction register never read back
// - decode select and direction four ways
// - busy blocks further instructions
// - counter holds loaded ram address
// - counter steps after each ram access
// - text ram holds eighty bytes
// - one-line addresses 00 to 4f
// - two-line addresses 00-27 and 40-67
// - serial dots for extension driver
// - latch pulse and shift pulse outputs
// - alternating phase output for ac drive
// - duty one eighth, eleventh, sixteenth
// - width bit high eight, low four
// - 4-bit mode uses two transfers
// - entry bit chooses increment or decrement
module clhi_top #(
    parameter int OP_CYCLES = `CLHI_OP_CYCLES
) (
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire logic I_PATH_SELECT_IN,
    input wire logic I_READ_NOT_WRITE,
    input wire logic I_ENABLE,
    input wire logic [3:0] I_LOW_BUS_LINES,
    output logic [3:0] O_LOW_BUS_LINES,
    output logic O_LOW_BUS_OE,
    input wire logic [3:0] I_HIGH_BUS_LINES,
    output logic [3:0] O_HIGH_BUS_LINES,
    output logic O_HIGH_BUS_OE,
    output logic O_EXT_LATCH_PULSE,
    output logic O_EXT_SHIFT_PULSE,
    output logic O_EXT_DATA,
    output logic O_AC_PHASE,
    output logic [1:0] O_DUTY,
    output logic O_INTERNAL_OP_FLAG
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] rs_s;
        logic [2:0] rw_s;
        logic [2:0] en_s;
        logic [15:0] dat_s0;
        logic [7:0] dat;
        logic [7:0] instruction_holding;
        logic [7:0] data_holding;
        logic [6:0] ram_address_counter;
        logic cg_sel;
        logic bus_width_sel;
        logic two_line;
        logic big_font;
        logic inc_dir;
        logic nib_low;
        logic [3:0] nib_hi;
        logic [15:0] op_cnt;
        clhi_pkg::clhi_state_type state;
        logic [5:0] ext_cnt;
        logic [15:0] frame_cnt;
        logic phase;
        logic shift_p;
        logic latch_p;
        logic ext_d;
        logic [7:0] rd_out;
    } clhi_top_type;
    clhi_top_type st_r, st_nxt;
    logic [7:0] dd_ram_r [`CLHI_DD_WORDS];
    logic [7:0] cg_ram_r [`CLHI_CG_WORDS];
    logic f_valid, f_ready, q_valid, q_ready, ram_wr;
    logic [7:0] f_data, q_data;
    logic [6:0] wr_addr;
    logic wr_cg;
    logic [15:0] dly;
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // maps the counter onto a flat text ram index
    function automatic logic [6:0] dd_index(input logic [6:0] a, input logic two);
        if (two && a >= `CLHI_DD_LINE2_FIRST) begin
            dd_index = a - `CLHI_DD_LINE2_FIRST + 7'h28;
        end else begin
            dd_index = a;
        end
    endfunction
    // next address, wrapping inside the valid ranges
    function automatic logic [6:0] step(input logic [6:0] a, input logic up,
            input logic two, input logic cg);
        if (cg) begin
            step = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
        end else if (up) begin
            if (!two) begin
                step = (a == `CLHI_DD_ONE_LAST) ? 7'h00 : a + 7'h01;
            end else if (a == `CLHI_DD_LINE1_LAST) begin
                step = `CLHI_DD_LINE2_FIRST;
            end else if (a == `CLHI_DD_LINE2_LAST) begin
                step = 7'h00;
            end else begin
                step = a + 7'h01;
            end
        end else begin
            if (!two) begin
                step = (a == 7'h00) ? `CLHI_DD_ONE_LAST : a - 7'h01;
            end else if (a == `CLHI_DD_LINE2_FIRST) begin
                step = `CLHI_DD_LINE1_LAST;
            end else if (a == 7'h00) begin
                step = `CLHI_DD_LINE2_LAST;
            end else begin
                step = a - 7'h01;
            end
        end
    endfunction
    // ----------------------------------------------------------------
    // write buffer
    // ----------------------------------------------------------------
    // host data bytes queue here; busy holds while the queue drains
    clhi_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
        .I_MCLK(I_MCLK),
        .I_RESET_N(I_RESET_N),
        .i_in_valid(f_valid),
        .o_in_ready(f_ready),
        .i_in_data(f_data),
        .o_out_valid(q_valid),
        .i_out_ready(q_ready),
        .o_out_data(q_data)
    );
    assign dly = 16'(OP_CYCLES);
    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic fall, rd, wr;
    logic [7:0] byte_in;
    logic byte_done;
    always_comb begin
        st_nxt = st_r;
        f_valid = 1'b0;
        f_data = st_r.data_holding;
        q_ready = 1'b0;
        ram_wr = 1'b0;
        wr_addr = st_r.ram_address_counter;
        wr_cg = st_r.cg_sel;
        st_nxt.rs_s = {st_r.rs_s[1:0], I_PATH_SELECT_IN};
        st_nxt.rw_s = {st_r.rw_s[1:0], I_READ_NOT_WRITE};
        st_nxt.en_s = {st_r.en_s[1:0], I_ENABLE};
        st_nxt.dat_s0 = {st_r.dat_s0[7:0], I_HIGH_BUS_LINES, I_LOW_BUS_LINES};
        st_nxt.dat = st_r.dat_s0[15:8];
        // strobe edge after two sync stages
        fall = st_r.en_s[2] && !st_r.en_s[1];
        rd = fall && st_r.rw_s[2];
        wr = fall && !st_r.rw_s[2];
        byte_in = st_r.bus_width_sel ? st_r.dat : {st_r.nib_hi, st_r.dat[7:4]};
        byte_done = st_r.bus_width_sel || st_r.nib_low;
        if (fall && !st_r.bus_width_sel) begin
            st_nxt.nib_low = !st_r.nib_low;
            if (!st_r.nib_low) begin
                st_nxt.nib_hi = st_r.dat[7:4];
            end
        end
        // read data presented on strobe rise so it stands while enable is high
        if (st_r.en_s[1] && !st_r.en_s[2]) begin
            st_nxt.rd_out = st_r.rs_s[1]
                ? st_r.data_holding
                : {st_r.state != clhi_pkg::CLHI_IDLE, st_r.ram_address_counter};
        end
        unique case (st_r.state)
            clhi_pkg::CLHI_IDLE: begin
                if (wr && byte_done && !st_r.rs_s[2]) begin
                    st_nxt.instruction_holding = byte_in;
                    st_nxt.op_cnt = dly;
                    st_nxt.state = clhi_pkg::CLHI_BUSY;
                    if (byte_in[7]) begin
                        st_nxt.ram_address_counter = byte_in[6:0];
                        st_nxt.cg_sel = 1'b0;
                    end else if (byte_in[6]) begin
                        st_nxt.ram_address_counter = {1'b0, byte_in[5:0]};
                        st_nxt.cg_sel = 1'b1;
                    end else if (byte_in[5]) begin
                        st_nxt.bus_width_sel = byte_in[`CLHI_BIT_DL];
                        st_nxt.two_line = byte_in[`CLHI_BIT_N];
                        st_nxt.big_font = byte_in[`CLHI_BIT_F];
                        st_nxt.nib_low = 1'b0;
                    end else if (byte_in[7:2] == 6'h01) begin
                        st_nxt.inc_dir = byte_in[`CLHI_BIT_ID];
                    end else if (byte_in[7:1] == 7'h01) begin
                        st_nxt.ram_address_counter = 7'h00;
                    end
                end else if (wr && byte_done && f_ready) begin
                    f_valid = 1'b1;
                    f_data = byte_in;
                    st_nxt.data_holding = byte_in;
                    st_nxt.state = clhi_pkg::CLHI_FILL;
                end else if (rd && byte_done && st_r.rs_s[2]) begin
                    st_nxt.ram_address_counter = step(st_r.ram_address_counter, st_r.inc_dir,
                        st_r.two_line, st_r.cg_sel);
                    st_nxt.state = clhi_pkg::CLHI_FILL;
                end
            end
            clhi_pkg::CLHI_BUSY: begin
                st_nxt.op_cnt = st_r.op_cnt - 16'h0001;
                if (st_r.op_cnt <= 16'h0001) begin
                    st_nxt.state = clhi_pkg::CLHI_FILL;
                end
            end
            clhi_pkg::CLHI_FILL: begin
                // drains queued data writes, then refreshes the read-ahead byte
                if (q_valid) begin
                    q_ready = 1'b1;
                    ram_wr = 1'b1;
                    st_nxt.ram_address_counter = step(st_r.ram_address_counter, st_r.inc_dir,
                        st_r.two_line, st_r.cg_sel);
                end else begin
                    st_nxt.data_holding = st_r.cg_sel
                        ? cg_ram_r[st_r.ram_address_counter[5:0]]
                        : dd_ram_r[dd_index(st_r.ram_address_counter, st_r.two_line)];
                    st_nxt.state = clhi_pkg::CLHI_IDLE;
                end
            end
            default: begin
                st_nxt.state = clhi_pkg::CLHI_IDLE;
            end
        endcase
        // extension driver: shift one dot every two cycles from the bits of text ram byte 8, latching every 40 dots
        st_nxt.shift_p = !st_r.shift_p;
        st_nxt.latch_p = 1'b0;
        if (st_r.shift_p) begin
            st_nxt.ext_cnt = (st_r.ext_cnt == 6'(`CLHI_EXT_BITS - 1)) ? 6'h00
                : st_r.ext_cnt + 6'h01;
            st_nxt.latch_p = st_r.ext_cnt == 6'(`CLHI_EXT_BITS - 1);
            st_nxt.ext_d = dd_ram_r[7'(`CLHI_SEG_BITS / 5)][st_r.ext_cnt[2:0]];
        end
        st_nxt.frame_cnt = st_r.frame_cnt + 16'h0001;
        if (st_r.frame_cnt == `CLHI_FRAME_DIV) begin
            st_nxt.frame_cnt = 16'h0000;
            st_nxt.phase = !st_r.phase;
        end
    end
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            st_r <= '0;
            st_r.bus_width_sel <= 1'b1;
            st_r.inc_dir <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end
    // ram writes come only from the drained queue, one per cycle
    always_ff @(posedge I_MCLK) begin
        if (ram_wr) begin
            if (wr_cg) begin
                cg_ram_r[wr_addr[5:0]] <= q_data;
            end else begin
                dd_ram_r[dd_index(wr_addr, st_r.two_line)] <= q_data;
            end
        end
    end
    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic drive;
    assign drive = I_ENABLE && st_r.rw_s[1];
    assign O_HIGH_BUS_LINES = (st_r.bus_width_sel || !st_r.nib_low)
        ? st_r.rd_out[7:4] : st_r.rd_out[3:0];
    assign O_LOW_BUS_LINES = st_r.rd_out[3:0];
    assign O_HIGH_BUS_OE = drive;
    assign O_LOW_BUS_OE = drive && st_r.bus_width_sel;
    assign O_EXT_LATCH_PULSE = st_r.latch_p;
    assign O_EXT_SHIFT_PULSE = st_r.shift_p;
    assign O_EXT_DATA = st_r.ext_d;
    assign O_AC_PHASE = st_r.phase;
    assign O_DUTY = st_r.two_line ? clhi_pkg::CLHI_DUTY16
        : (st_r.big_font ? clhi_pkg::CLHI_DUTY11 : clhi_pkg::CLHI_DUTY8);
    assign O_INTERNAL_OP_FLAG = st_r.state != clhi_pkg::CLHI_IDLE;
endmodule

// ### tb/clhi_checker.sv
// assertion checker for the lcd host port pins
`timescale 1ns/100ps
module clhi_checker #(
    parameter int OP_CYCLES = 40
) (
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire logic I_PATH_SELECT_IN,
    input wire logic I_READ_NOT_WRITE,
    input wire logic I_ENABLE,
    input wire logic [3:0] I_LOW_BUS_LINES,
    input wire logic [3:0] O_LOW_BUS_LINES,
    input wire logic O_LOW_BUS_OE,
    input wire logic [3:0] I_HIGH_BUS_LINES,
    input wire logic [3:0] O_HIGH_BUS_LINES,
    input wire logic O_HIGH_BUS_OE,
    input wire logic O_EXT_LATCH_PULSE,
    input wire logic O_EXT_SHIFT_PULSE,
    input wire logic O_EXT_DATA,
    input wire logic O_AC_PHASE,
    input wire logic [1:0] O_DUTY,
    input wire logic O_INTERNAL_OP_FLAG
);
    // ----
    // checks
    // ----
    logic phase_r;
    logic [10:0] still_r;
    logic [7:0] busy_cnt_r;
    // counters stand in for long repetitions, which the tools unroll slowly
    always_ff @(posedge I_MCLK) begin
        phase_r <= O_AC_PHASE;
        still_r <= (!I_RESET_N || O_AC_PHASE != phase_r) ? 11'h000 : still_r + 11'h001;
        busy_cnt_r <= (!I_RESET_N || !O_INTERNAL_OP_FLAG) ? 8'h00 : busy_cnt_r + 8'h01;
    end
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RESET_N);
    a_shift_each_cycle: assert property (
        $past(I_RESET_N) |-> O_EXT_SHIFT_PULSE != $past(O_EXT_SHIFT_PULSE))
        else $error("shift pulse did not toggle");
    a_latch_gap: assert property (O_EXT_LATCH_PULSE |=> !O_EXT_LATCH_PULSE [*8])
        else $error("latch pulse too long or too close");
    a_phase_period: assert property (still_r < 11'h44c)
        else $error("phase output stuck");
    a_busy_bounded: assert property (busy_cnt_r <= 8'(OP_CYCLES + 8))
        else $error("busy held too long");
    a_instr_sets_busy: assert property (
        $fell(I_ENABLE) && !I_PATH_SELECT_IN && !I_READ_NOT_WRITE && !O_INTERNAL_OP_FLAG
        |-> ##[1:32] O_INTERNAL_OP_FLAG)
        else $error("instruction did not raise busy");
    a_oe_read_only: assert property (O_HIGH_BUS_OE |-> I_READ_NOT_WRITE)
        else $error("bus driven during write");
    a_low_oe_subset: assert property (O_LOW_BUS_OE |-> O_HIGH_BUS_OE)
        else $error("low lines driven alone");
    a_oe_release: assert property ($fell(I_ENABLE) |-> ##[1:5] !O_HIGH_BUS_OE)
        else $error("bus not released after strobe");
    a_oe_needs_strobe: assert property ($rose(O_HIGH_BUS_OE) |-> I_ENABLE)
        else $error("bus driven without strobe");
    a_duty_code: assert property (O_DUTY != 2'h3)
        else $error("illegal duty code");
    c_latch: cover property (O_EXT_LATCH_PULSE);
    c_busy: cover property ($rose(O_INTERNAL_OP_FLAG));
    c_low_oe: cover property (O_LOW_BUS_OE);
endmodule
bind clhi_top clhi_checker #(.OP_CYCLES(OP_CYCLES)) chk_u (.I_MCLK(I_MCLK),
    .I_RESET_N(I_RESET_N), .I_PATH_SELECT_IN(I_PATH_SELECT_IN),
    .I_READ_NOT_WRITE(I_READ_NOT_WRITE), .I_ENABLE(I_ENABLE), .I_LOW_BUS_LINES(I_LOW_BUS_LINES),
    .O_LOW_BUS_LINES(O_LOW_BUS_LINES), .O_LOW_BUS_OE(O_LOW_BUS_OE),
    .I_HIGH_BUS_LINES(I_HIGH_BUS_LINES), .O_HIGH_BUS_LINES(O_HIGH_BUS_LINES),
    .O_HIGH_BUS_OE(O_HIGH_BUS_OE), .O_EXT_LATCH_PULSE(O_EXT_LATCH_PULSE),
    .O_EXT_SHIFT_PULSE(O_EXT_SHIFT_PULSE), .O_EXT_DATA(O_EXT_DATA), .O_AC_PHASE(O_AC_PHASE),
    .O_DUTY(O_DUTY), .O_INTERNAL_OP_FLAG(O_INTERNAL_OP_FLAG));

// ### tb/clhi_host.sv
// host processor model for the lcd controller parallel port
`timescale 1ns/100ps
module clhi_host (
    input wire logic i_mclk,
    output logic o_path_select,
    output logic o_read_not_write,
    output logic o_enable,
    output logic [3:0] o_high_wire,
    output logic [3:0] o_low_wire,
    input wire logic [3:0] i_high_out,
    input wire logic i_high_oe,
    input wire logic [3:0] i_low_out,
    input wire logic i_low_oe
);
    // ----
    // bus wires and strobe sequencing
    // ----
    logic four = 1'b0;
    logic drv = 1'b0;
    logic [3:0] hv = 4'h0;
    logic [3:0] lv = 4'h0;
    logic [3:0] flt = 4'h5;
    initial begin
        o_path_select = 1'b0;
        o_read_not_write = 1'b1;
        o_enable = 1'b0;
    end
    always @(posedge i_mclk) flt <= ~flt;
    // released lines flip each cycle so stale data never passes for a reply
    assign o_high_wire = (i_high_oe === 1'b1) ? i_high_out : (drv ? hv : flt);
    assign o_low_wire = (i_low_oe === 1'b1) ? i_low_out : ((drv && !four) ? lv : ~flt);
    task automatic strobe(input logic rs, input logic rw, input logic [3:0] h,
                          input logic [3:0] l, output logic [3:0] qh, output logic [3:0] ql);
        @(posedge i_mclk);
        o_path_select <= rs;
        o_read_not_write <= rw;
        hv <= h;
        lv <= l;
        drv <= !rw;
        // select and direction pass two sync stages, so they must settle before the strobe
        repeat (3) @(posedge i_mclk);
        o_enable <= 1'b1;
        repeat (8) @(posedge i_mclk);
        qh = o_high_wire;
        ql = o_low_wire;
        o_enable <= 1'b0;
        // eight low cycles also give the half-period gap after busy clears
        repeat (8) @(posedge i_mclk);
        drv <= 1'b0;
    endtask
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
        logic [3:0] a, b, c, e;
        if (four) begin
            strobe(rs, rw, d[7:4], 4'h0, a, b);
            strobe(rs, rw, d[3:0], 4'h0, c, e);
            q = {a, c};
        end else begin
            strobe(rs, rw, d[7:4], d[3:0], a, b);
            q = {a, b};
        end
    endtask
    task automatic poll(output logic [7:0] s);
        int n;
        n = 0;
        do begin
            xfer(1'b0, 1'b1, 8'h00, s);
            n++;
        end while (s[7] !== 1'b0 && n < 20);
    endtask
endmodule

// ### tb/tb.sv
// self-checking bench for the lcd host port
`timescale 1ns/100ps
module tb;
    // ----
    // design, host and sequence
    // ----
    logic I_MCLK = 1'b0;
    logic I_RESET_N = 1'b0;
    logic rs, rw, en, lo_oe, hi_oe, latch, shift, dot, phase, busy;
    logic [3:0] hi_w, lo_w, hi_o, lo_o;
    logic [1:0] duty;
    int failures = 0;
    int checked = 0;
    logic [31:0] lfsr_r = 32'hdeb0;
    logic [7:0] q, s;
    logic [7:0] mem [4];
    logic [6:0] ac = 7'h00;
    logic up = 1'b1;
    logic [6:0] lims [3] = '{7'h4f, 7'h27, 7'h00};
    logic [7:0] fns [3] = '{8'h30, 8'h34, 8'h38};
    always #25 I_MCLK = ~I_MCLK;
    clhi_top #(.OP_CYCLES(40)) dut_u (.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N),
        .I_PATH_SELECT_IN(rs), .I_READ_NOT_WRITE(rw), .I_ENABLE(en), .I_LOW_BUS_LINES(lo_w),
        .O_LOW_BUS_LINES(lo_o), .O_LOW_BUS_OE(lo_oe), .I_HIGH_BUS_LINES(hi_w),
        .O_HIGH_BUS_LINES(hi_o), .O_HIGH_BUS_OE(hi_oe), .O_EXT_LATCH_PULSE(latch),
        .O_EXT_SHIFT_PULSE(shift), .O_EXT_DATA(dot), .O_AC_PHASE(phase), .O_DUTY(duty),
        .O_INTERNAL_OP_FLAG(busy));
    clhi_host host_u (.i_mclk(I_MCLK), .o_path_select(rs), .o_read_not_write(rw),
        .o_enable(en), .o_high_wire(hi_w), .o_low_wire(lo_w), .i_high_out(hi_o),
        .i_high_oe(hi_oe), .i_low_out(lo_o), .i_low_oe(lo_oe));
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        host_u.xfer(1'b0, 1'b0, c, q);
        host_u.poll(s);
    endtask
    task automatic status(input string what);
        host_u.poll(s);
        check(s, {1'b0, ac}, what);
    endtask
    task automatic acc(input logic rd, input logic [7:0] d);
        host_u.xfer(1'b1, rd, d, q);
        if (rd) check(q, d, "read data");
        ac = up ? ac + 7'h01 : ac - 7'h01;
        status("address step");
    endtask
    task automatic conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge I_MCLK);
        I_RESET_N <= 1'b1;
        status("reset status");
        for (int i = 0; i < 3; i++) begin
            ac = lims[i];
            cmd({1'b1, lims[i]});
            status("address set");
            cmd(fns[i]);
            check({6'h00, duty}, 8'(i), "duty select");
        end
        ac = 7'h40;
        cmd(8'hc0);
        for (int i = 0; i < 4; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            mem[i] = lfsr_r[7:0];
            acc(1'b0, mem[i]);
        end
        ac = 7'h40;
        cmd(8'hc0);
        for (int i = 0; i < 4; i++) acc(1'b1, mem[i]);
        cmd(8'h04);
        up = 1'b0;
        acc(1'b0, 8'h5a);
        cmd(8'h06);
        up = 1'b1;
        host_u.xfer(1'b0, 1'b0, 8'h90, q);
        ac = 7'h10;
        cmd(8'ha0);
        status("busy refusal");
        host_u.xfer(1'b0, 1'b0, 8'h28, q);
        host_u.four = 1'b1;
        status("nibble status");
        lfsr_r = lfsr_next(lfsr_r);
        for (int i = 0; i < 2; i++) begin
            ac = 7'h44;
            cmd(8'hc4);
            acc(i[0], lfsr_r[7:0]);
        end
        host_u.xfer(1'b0, 1'b0, 8'h30, q);
        host_u.four = 1'b0;
        status("wide again");
        // a second reset in mid-run must bring back address zero and one-eighth duty
        I_RESET_N <= 1'b0;
        repeat (2) @(posedge I_MCLK);
        I_RESET_N <= 1'b1;
        ac = 7'h00;
        status("second reset");
        check({6'h00, duty}, 8'h00, "duty after reset");
        conclude();
    end
    // the sequence needs some 2000 cycles, so this leaves a wide margin
    initial begin
        repeat (40000) @(posedge I_MCLK);
        failures++;
        conclude();
    end
endmodule
